// *** rtl/hbcf_pkg.sv ***
// Overview of operation
// - Awake bridge decodes inputs: 00 coast, 01 reverse, 10 forward, 11 brake.
// - Any terminal swapping high and low passes through a high-impedance dead interval.
// - Sense comparator per bridge flags a trip at the 200 mV reference.
// - A trip forces both low sides on for the decay hold time.
// - After the decay hold the outputs follow the decoded inputs again.
// - An input change during decay hold ends the hold at once.
// - Trip still present after hold: drive for blanking time, then hold again.
// - Limit active past the deglitch time disables that bridge and asserts fault.
// - After the retry time the bridge restarts and fault releases; repeats if persists.
// - Overcurrent shutdown affects only the bridge where it was detected.
// - High side, low side and sense overcurrent all count as overcurrent.
// - Over-temperature disables all switches and asserts fault until it clears.
// - Supply lockout disables everything, resets logic, asserts fault until supply recovers.
// - Active only with supply good, wake delay elapsed, and sleep pin high or low for less than the sleep entry delay.
// - Sleep pin low for the sleep entry delay puts all outputs high-impedance.
// - Power-up with sleep pin low goes straight to sleep; wake needs the delay.
// - Fault disables the affected bridge, asserts fault, and recovers automatically.
package hbcf_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned DECAY_HOLD_NS = 20000;
    localparam int unsigned BLANKING_NS = 1000;
    localparam int unsigned DEGLITCH_NS = 1000;
    localparam int unsigned RETRY_US = 1000;
    localparam int unsigned WAKE_US = 100;
    localparam int unsigned SLEEP_US = 100;
    localparam int unsigned DEAD_NS = 200;
    localparam int unsigned DECAY_HOLD_CYC = DECAY_HOLD_NS * CLK_MHZ / 1000;
    localparam int unsigned BLANKING_CYC = BLANKING_NS * CLK_MHZ / 1000;
    localparam int unsigned DEGLITCH_CYC = DEGLITCH_NS * CLK_MHZ / 1000;
    localparam int unsigned RETRY_CYC = RETRY_US * CLK_MHZ;
    localparam int unsigned WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int unsigned SLEEP_CYC = SLEEP_US * CLK_MHZ;
    localparam int unsigned DEAD_CYC = DEAD_NS * CLK_MHZ / 1000;
    localparam int unsigned CNT_W = 20;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        HBCF_COAST   = 2'b00,
        HBCF_REVERSE = 2'b01,
        HBCF_FORWARD = 2'b10,
        HBCF_BRAKE   = 2'b11
    } hbcf_drive_e;

    // Terminal drive request: on means driven, high selects high side
    typedef struct packed {
        logic on;
        logic high;
    } hbcf_term_s;

    // Per-bridge analog monitor flags
    typedef struct packed {
        logic chop_trip;
        logic hs_limit;
        logic ls_limit;
        logic sense_ocp;
    } hbcf_sense_s;

    typedef enum logic [1:0] {
        HBCF_ST_SLEEP = 2'b00,
        HBCF_ST_WAKE  = 2'b01,
        HBCF_ST_ACT   = 2'b10,
        HBCF_ST_ENTER = 2'b11
    } hbcf_mode_e;

endpackage

// *** rtl/hbcf_term.sv ***
// One bridge terminal with dead interval on every high/low swap
module hbcf_term
    import hbcf_pkg::*;
#(
    parameter int unsigned DEAD_CYCLES = DEAD_CYC
) (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire hbcf_term_s req_in,
    output logic hs_on_out,
    output logic ls_on_out
);
    logic [7:0] dead_q, dead_d;
    logic hs_q, hs_d, ls_q, ls_d;

    always_comb begin
        dead_d = (dead_q != 8'h00) ? dead_q - 8'h01 : 8'h00;
        hs_d = 1'b0;
        ls_d = 1'b0;
        if (hs_q || ls_q) begin
            if (!req_in.on || (req_in.high != hs_q)) begin
                // Release and hold off, so a one-cycle coast cannot shorten the gap
                dead_d = 8'(DEAD_CYCLES);
            end else begin
                hs_d = hs_q;
                ls_d = ls_q;
            end
        end else if (req_in.on && dead_q == 8'h00) begin
            hs_d = req_in.high;
            ls_d = !req_in.high;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            dead_q <= 8'h00;
            hs_q <= 1'b0;
            ls_q <= 1'b0;
        end else begin
            dead_q <= dead_d;
            hs_q <= hs_d;
            ls_q <= ls_d;
        end
    end

    assign hs_on_out = hs_q;
    assign ls_on_out = ls_q;
endmodule

// *** rtl/hbcf_bridge.sv ***
// Per-bridge decode, chopping and overcurrent retry
module hbcf_bridge
    import hbcf_pkg::*;
#(
    parameter int unsigned DECAY_CYCLES = DECAY_HOLD_CYC,
    parameter int unsigned BLANK_CYCLES = BLANKING_CYC,
    parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYC,
    parameter int unsigned RETRY_CYCLES = RETRY_CYC
) (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic enable_in,
    input  wire logic [1:0] ctrl_in,
    input  wire hbcf_sense_s sense_in,
    output hbcf_term_s term_a_out,
    output hbcf_term_s term_b_out,
    output logic ocp_out
);
    typedef enum logic [1:0] {
        HB_DRIVE = 2'b00,
        HB_DECAY = 2'b01,
        HB_BLANK = 2'b10,
        HB_OCP   = 2'b11
    } hb_state_e;

    hb_state_e st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] deg_q, deg_d;
    logic [1:0] ctrl_prev_q;
    logic limit;
    hbcf_drive_e drv;

    assign limit = sense_in.hs_limit | sense_in.ls_limit | sense_in.sense_ocp;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        deg_d = (limit && st_q != HB_OCP) ? deg_q + 1'b1 : '0;
        unique case (st_q)
            HB_DRIVE: begin
                if (sense_in.chop_trip) begin
                    st_d = HB_DECAY;
                    cnt_d = CNT_W'(DECAY_CYCLES);
                end
            end
            HB_DECAY: begin
                if (ctrl_in != ctrl_prev_q) begin
                    st_d = HB_DRIVE;
                end else if (cnt_q <= CNT_W'(1)) begin
                    if (sense_in.chop_trip) begin
                        st_d = HB_BLANK;
                        cnt_d = CNT_W'(BLANK_CYCLES);
                    end else begin
                        st_d = HB_DRIVE;
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            HB_BLANK: begin
                if (cnt_q <= CNT_W'(1)) begin
                    st_d = HB_DECAY;
                    cnt_d = CNT_W'(DECAY_CYCLES);
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            HB_OCP: begin
                if (cnt_q <= CNT_W'(1)) begin
                    st_d = HB_DRIVE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase
        if (deg_q >= CNT_W'(DEGLITCH_CYCLES)) begin
            st_d = HB_OCP;
            cnt_d = CNT_W'(RETRY_CYCLES);
            deg_d = '0;
        end
        if (!enable_in) begin
            st_d = HB_DRIVE;
            cnt_d = '0;
            deg_d = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_q <= HB_DRIVE;
            cnt_q <= '0;
            deg_q <= '0;
            ctrl_prev_q <= 2'b00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            deg_q <= deg_d;
            ctrl_prev_q <= ctrl_in;
        end
    end

    always_comb begin
        drv = hbcf_drive_e'(ctrl_in);
        if (st_q == HB_DECAY) begin
            drv = HBCF_BRAKE;
        end
        unique case (drv)
            HBCF_COAST: begin
                term_a_out = '{on: 1'b0, high: 1'b0};
                term_b_out = '{on: 1'b0, high: 1'b0};
            end
            HBCF_REVERSE: begin
                term_a_out = '{on: 1'b1, high: 1'b0};
                term_b_out = '{on: 1'b1, high: 1'b1};
            end
            HBCF_FORWARD: begin
                term_a_out = '{on: 1'b1, high: 1'b1};
                term_b_out = '{on: 1'b1, high: 1'b0};
            end
            HBCF_BRAKE: begin
                term_a_out = '{on: 1'b1, high: 1'b0};
                term_b_out = '{on: 1'b1, high: 1'b0};
            end
        endcase
        if (!enable_in || st_q == HB_OCP) begin
            term_a_out = '{on: 1'b0, high: 1'b0};
            term_b_out = '{on: 1'b0, high: 1'b0};
        end
    end

    assign ocp_out = (st_q == HB_OCP);
endmodule

// *** rtl/hbcf_top.sv ***
// Dual bridge chopping and fault control
module hbcf_top
    import hbcf_pkg::*;
#(
    parameter int unsigned DECAY_CYCLES = DECAY_HOLD_CYC,
    parameter int unsigned BLANK_CYCLES = BLANKING_CYC,
    parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYC,
    parameter int unsigned RETRY_CYCLES = RETRY_CYC,
    parameter int unsigned WAKE_CYCLES = WAKE_CYC,
    parameter int unsigned SLEEP_CYCLES = SLEEP_CYC,
    parameter int unsigned DEAD_CYCLES = DEAD_CYC
) (
    // Clock and reset
    input  wire logic CLK_IN,
    input  wire logic NRST_IN,
    // Controller pins
    input  wire logic SLEEP_REQUEST_LOW_IN,
    input  wire logic [1:0] BRIDGE_CONTROL_A_IN,
    input  wire logic [1:0] BRIDGE_CONTROL_B_IN,
    // Analog monitors, sense flags one per bridge
    input  wire hbcf_pkg::hbcf_sense_s [1:0] SENSE_IN,
    input  wire logic OVER_TEMP_IN,
    input  wire logic SUPPLY_LOCKOUT_IN,
    // Gate drive, [1:0] per bridge
    output logic [1:0] TERM_A_HS_OUT,
    output logic [1:0] TERM_A_LS_OUT,
    output logic [1:0] TERM_B_HS_OUT,
    output logic [1:0] TERM_B_LS_OUT,
    // Open-drain fault flag, enable low pulls pin low
    output logic FAULT_FLAG_LOW_OUT,
    output logic FAULT_FLAG_LOW_OE_N_OUT,
    output logic ACTIVE_OUT
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int SW = 4 + 8 + 3;
    logic [SW-1:0] s1_q, s2_q;
    logic sleep_n, otp, supply_lockout;
    logic [1:0] ctl_a, ctl_b;
    hbcf_sense_s [1:0] sense;

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {SLEEP_REQUEST_LOW_IN, OVER_TEMP_IN, SUPPLY_LOCKOUT_IN,
                     BRIDGE_CONTROL_A_IN, BRIDGE_CONTROL_B_IN, SENSE_IN};
            s2_q <= s1_q;
        end
    end
    assign {sleep_n, otp, supply_lockout, ctl_a, ctl_b, sense} = s2_q;

    // ************************************************************
    // Mode sequencing
    // ************************************************************
    hbcf_mode_e mode_q, mode_d;
    logic [CNT_W-1:0] tmr_q, tmr_d;
    logic run;

    always_comb begin
        mode_d = mode_q;
        tmr_d = tmr_q;
        unique case (mode_q)
            HBCF_ST_SLEEP: begin
                if (sleep_n) begin
                    mode_d = HBCF_ST_WAKE;
                    tmr_d = CNT_W'(WAKE_CYCLES);
                end
            end
            HBCF_ST_WAKE: begin
                if (!sleep_n) begin
                    mode_d = HBCF_ST_SLEEP;
                end else if (tmr_q <= CNT_W'(1)) begin
                    mode_d = HBCF_ST_ACT;
                end else begin
                    tmr_d = tmr_q - 1'b1;
                end
            end
            HBCF_ST_ACT: begin
                if (!sleep_n) begin
                    mode_d = HBCF_ST_ENTER;
                    tmr_d = CNT_W'(SLEEP_CYCLES);
                end
            end
            HBCF_ST_ENTER: begin
                if (sleep_n) begin
                    mode_d = HBCF_ST_ACT;
                end else if (tmr_q <= CNT_W'(1)) begin
                    mode_d = HBCF_ST_SLEEP;
                end else begin
                    tmr_d = tmr_q - 1'b1;
                end
            end
        endcase
        if (supply_lockout) begin
            // Lockout restarts the wake sequence from sleep
            mode_d = HBCF_ST_SLEEP;
            tmr_d = '0;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            mode_q <= HBCF_ST_SLEEP;
            tmr_q <= '0;
        end else begin
            mode_q <= mode_d;
            tmr_q <= tmr_d;
        end
    end

    // Bridges keep running until the sleep entry delay ends
    assign run = (mode_q == HBCF_ST_ACT || mode_q == HBCF_ST_ENTER) && !supply_lockout && !otp;

    // ************************************************************
    // Bridges
    // ************************************************************
    logic [1:0] overcurrent_shutdown;
    logic [1:0] a_hs, a_ls, b_hs, b_ls;
    logic [1:0][1:0] ctl;
    assign ctl[0] = ctl_a;
    assign ctl[1] = ctl_b;

    for (genvar g = 0; g < 2; g++) begin : g_br
        hbcf_term_s ta, tb;
        hbcf_bridge #(
            .DECAY_CYCLES(DECAY_CYCLES),
            .BLANK_CYCLES(BLANK_CYCLES),
            .DEGLITCH_CYCLES(DEGLITCH_CYCLES),
            .RETRY_CYCLES(RETRY_CYCLES)
        ) u_br (
            .clk_in(CLK_IN),
            .nrst_in(NRST_IN),
            .enable_in(run),
            .ctrl_in(ctl[g]),
            .sense_in(sense[g]),
            .term_a_out(ta),
            .term_b_out(tb),
            .ocp_out(overcurrent_shutdown[g])
        );
        hbcf_term #(.DEAD_CYCLES(DEAD_CYCLES)) u_ta (
            .clk_in(CLK_IN),
            .nrst_in(NRST_IN),
            .req_in(ta),
            .hs_on_out(a_hs[g]),
            .ls_on_out(a_ls[g])
        );
        hbcf_term #(.DEAD_CYCLES(DEAD_CYCLES)) u_tb (
            .clk_in(CLK_IN),
            .nrst_in(NRST_IN),
            .req_in(tb),
            .hs_on_out(b_hs[g]),
            .ls_on_out(b_ls[g])
        );
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    logic fault_d, fault_q, act_q;
    assign fault_d = supply_lockout | otp | (|overcurrent_shutdown);

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            fault_q <= 1'b0;
            act_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
            act_q <= run;
        end
    end

    // Terminal stage outputs are already registered
    assign TERM_A_HS_OUT = a_hs;
    assign TERM_A_LS_OUT = a_ls;
    assign TERM_B_HS_OUT = b_hs;
    assign TERM_B_LS_OUT = b_ls;
    assign FAULT_FLAG_LOW_OUT = 1'b0;
    assign FAULT_FLAG_LOW_OE_N_OUT = !fault_q;
    assign ACTIVE_OUT = act_q;
endmodule

// *** verification/hbcf_checker.sv ***
module hbcf_checker
    import hbcf_pkg::*;
#(
    parameter int unsigned DEGLITCH_CYCLES = 8,
    parameter int unsigned WAKE_CYCLES = 20
) (
    // Design ports
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic SLEEP_REQUEST_LOW_IN,
    input wire logic [1:0] BRIDGE_CONTROL_A_IN,
    input wire hbcf_pkg::hbcf_sense_s [1:0] SENSE_IN,
    input wire logic OVER_TEMP_IN,
    input wire logic SUPPLY_LOCKOUT_IN,
    input wire logic [1:0] TERM_A_HS_OUT,
    input wire logic [1:0] TERM_A_LS_OUT,
    input wire logic [1:0] TERM_B_HS_OUT,
    input wire logic [1:0] TERM_B_LS_OUT,
    input wire logic FAULT_FLAG_LOW_OE_N_OUT,
    input wire logic ACTIVE_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] stab_q;
    logic [4:0] lim_q;
    int unsigned wake_q;
    logic [1:0] ctl_q;
    logic [3:0] exp_w;
    logic [3:0] got_w;
    logic quiet_w;
    logic off_w;

    // ********
    // Helpers
    // ********
    assign got_w = {TERM_A_HS_OUT[0], TERM_A_LS_OUT[0], TERM_B_HS_OUT[0], TERM_B_LS_OUT[0]};
    assign off_w = {TERM_A_HS_OUT, TERM_A_LS_OUT, TERM_B_HS_OUT, TERM_B_LS_OUT} == 8'h00;
    assign quiet_w = ACTIVE_OUT && SENSE_IN[0] == 4'h0 && !OVER_TEMP_IN && !SUPPLY_LOCKOUT_IN
        && FAULT_FLAG_LOW_OE_N_OUT && BRIDGE_CONTROL_A_IN == ctl_q;

    always_comb begin
        case (BRIDGE_CONTROL_A_IN)
            2'b01: exp_w = 4'h6;
            2'b10: exp_w = 4'h9;
            2'b11: exp_w = 4'h5;
            default: exp_w = 4'h0;
        endcase
    end

    // Stability and limit counters saturate so an old event cannot wrap round into a new match
    always_ff @(posedge CLK_IN) begin
        ctl_q <= BRIDGE_CONTROL_A_IN;
        stab_q <= (!NRST_IN || !quiet_w) ? 6'h00 : stab_q + {5'h00, stab_q != 6'h3f};
        lim_q <= (!NRST_IN || SENSE_IN[0][2:0] == 3'h0) ? 5'h00 : lim_q + {4'h0, lim_q != 5'h1f};
        wake_q <= (!NRST_IN || !SLEEP_REQUEST_LOW_IN || SUPPLY_LOCKOUT_IN) ? 0 : wake_q + 1;
    end

    // ********
    // Properties
    // ********
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!NRST_IN);

    a_no_shoot: assert property ((TERM_A_HS_OUT & TERM_A_LS_OUT) == 2'h0
        && (TERM_B_HS_OUT & TERM_B_LS_OUT) == 2'h0) else $error("both switches on");
    a_dead_hl: assert property ($fell(TERM_A_HS_OUT[0])
        |-> (!TERM_A_LS_OUT[0]) [*2]) else $error("no dead gap high to low");
    a_dead_lh: assert property ($fell(TERM_B_LS_OUT[0])
        |-> (!TERM_B_HS_OUT[0]) [*2]) else $error("no dead gap low to high");
    a_decode_follow: assert property (stab_q == 6'h30 |-> got_w == exp_w)
        else $error("outputs do not follow inputs");
    a_chop_enter: assert property ($rose(SENSE_IN[0].chop_trip)
        && stab_q >= 6'h30 && BRIDGE_CONTROL_A_IN == 2'b10
        |-> ##[2:14] (TERM_A_LS_OUT[0] && TERM_B_LS_OUT[0])) else $error("no decay hold");
    a_ocp_off: assert property (ACTIVE_OUT && lim_q == DEGLITCH_CYCLES + 8
        |-> !FAULT_FLAG_LOW_OE_N_OUT && got_w == 4'h0) else $error("no overcurrent stop");
    a_temp_off: assert property (OVER_TEMP_IN [*8]
        |-> !FAULT_FLAG_LOW_OE_N_OUT && off_w) else $error("no thermal stop");
    a_lock_off: assert property (SUPPLY_LOCKOUT_IN [*8]
        |-> !FAULT_FLAG_LOW_OE_N_OUT && !ACTIVE_OUT) else $error("no lockout stop");
    a_sleep_off: assert property ((!ACTIVE_OUT) [*6] |-> off_w)
        else $error("driving while inactive");
    a_wake_wait: assert property ($rose(ACTIVE_OUT) |-> wake_q >= WAKE_CYCLES)
        else $error("woke too early");
endmodule

bind hbcf_top hbcf_checker #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES), .WAKE_CYCLES(WAKE_CYCLES))
    u_hbcf_checker (.*);

// *** verification/hbcf_mcu_model.sv ***
module hbcf_mcu_model (
    // Clock and command from the bench
    input wire logic clk_in,
    input wire logic [4:0] cmd_in,
    // Controller pins
    output logic sleep_request_low_out,
    output logic [1:0] ctrl_a_out,
    output logic [1:0] ctrl_b_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {sleep_request_low_out, ctrl_a_out, ctrl_b_out} = 5'h00;
    // Pins move on the falling edge, well clear of the device's sampling edge
    always @(negedge clk_in) begin
        sleep_request_low_out <= cmd_in[4];
        ctrl_a_out <= cmd_in[3:2];
        ctrl_b_out <= cmd_in[1:0];
    end
endmodule

// *** verification/tb_top.sv ***
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import hbcf_pkg::*;
    localparam int DEC = 30;
    localparam int BLK = 8;
    localparam int DEG = 8;
    localparam int RET = 40;
    localparam int WAK = 20;
    localparam int SLP = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] cmd = 5'h00;
    hbcf_sense_s [1:0] sense = '0;
    logic temp = 1'b0;
    logic lock = 1'b0;
    logic slp_n;
    logic [1:0] ca, cb, hs_a, ls_a, hs_b, ls_b;
    logic oe_n, act, fpin;
    logic [5:0] mon;
    logic [3:0] dec_t [4] = '{4'h0, 4'h6, 4'h9, 4'h5};
    int failures = 0;
    int tests_run = 0;
    int n;
    assign mon = {act, oe_n, hs_a[0], ls_a[0], hs_b[0], ls_b[0]};

    initial forever #4 clk = ~clk;

    hbcf_mcu_model u_hbcf_mcu_model (.clk_in(clk), .cmd_in(cmd),
        .sleep_request_low_out(slp_n), .ctrl_a_out(ca), .ctrl_b_out(cb));
    hbcf_top #(.DECAY_CYCLES(DEC), .BLANK_CYCLES(BLK), .DEGLITCH_CYCLES(DEG),
        .RETRY_CYCLES(RET), .WAKE_CYCLES(WAK), .SLEEP_CYCLES(SLP), .DEAD_CYCLES(4)) u_hbcf_top (
        .CLK_IN(clk), .NRST_IN(rst_n), .SLEEP_REQUEST_LOW_IN(slp_n),
        .BRIDGE_CONTROL_A_IN(ca), .BRIDGE_CONTROL_B_IN(cb), .SENSE_IN(sense),
        .OVER_TEMP_IN(temp), .SUPPLY_LOCKOUT_IN(lock), .TERM_A_HS_OUT(hs_a),
        .TERM_A_LS_OUT(ls_a), .TERM_B_HS_OUT(hs_b), .TERM_B_LS_OUT(ls_b),
        .FAULT_FLAG_LOW_OUT(fpin), .FAULT_FLAG_LOW_OE_N_OUT(oe_n), .ACTIVE_OUT(act));

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // Bounded wait on one monitored output; n returns the cycles spent
    task automatic wt(input int s, input logic v, input int lim);
        n = 0;
        while (mon[s] !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (mon[s] !== v) begin
            failures++;
            $display("[ERR] %0t wait on output %0d ran out", $time, s);
        end
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_wake();
        cyc(30);
        `CHK(act, 1'b0)
        cmd[4] = 1'b1;
        wt(5, 1'b1, WAK + 20);
        `CHK(n >= WAK, 1'b1)
        $display("wake done");
    endtask

    task automatic t_decode();
        for (int i = 0; i < 4; i++) begin
            cmd[3:0] = {i[1:0], ~i[1:0]};
            cyc(56);
            `CHK(mon[3:0], dec_t[i])
            `CHK({hs_a[1], ls_a[1], hs_b[1], ls_b[1]}, dec_t[3 - i])
        end
        $display("decode done");
    endtask

    task automatic t_chop();
        cmd[3:2] = 2'b10;
        cyc(56);
        sense[0].chop_trip = 1'b1;
        cyc(2);
        sense[0].chop_trip = 1'b0;
        wt(2, 1'b1, 16);
        `CHK(mon[3:0], 4'h5)
        wt(3, 1'b1, DEC + 12);
        `CHK(n > 15, 1'b1)
        `CHK(mon[3:0], 4'h9)
        cyc(56);
        sense[0].chop_trip = 1'b1;
        cyc(2);
        sense[0].chop_trip = 1'b0;
        wt(2, 1'b1, 16);
        cmd[3:2] = 2'b01;
        wt(1, 1'b1, 14);
        `CHK(mon[3:0], 4'h6)
        cmd[3:2] = 2'b10;
        cyc(56);
        sense[0].chop_trip = 1'b1;
        wt(2, 1'b1, 16);
        wt(3, 1'b1, DEC + 12);
        wt(2, 1'b1, BLK + 14);
        `CHK(n > 2, 1'b1)
        `CHK(mon[3:0], 4'h5)
        sense[0].chop_trip = 1'b0;
        cyc(56);
        $display("chop done");
    endtask

    task automatic t_ocp();
        cmd[3:0] = 4'ha;
        cyc(56);
        for (int k = 0; k < 3; k++) begin
            sense[0][k] = 1'b1;
            wt(4, 1'b0, DEG + 14);
            cyc(2);
            `CHK(mon[3:0], 4'h0)
            `CHK({hs_a[1], ls_b[1]}, 2'b11)
            sense[0][k] = 1'b0;
            wt(4, 1'b1, RET + 14);
            `CHK(n >= RET - 4, 1'b1)
            cyc(20);
            `CHK(mon[3:0], 4'h9)
        end
        sense[0].sense_ocp = 1'b1;
        wt(4, 1'b0, DEG + 14);
        wt(4, 1'b1, RET + 14);
        wt(4, 1'b0, DEG + 14);
        `CHK(oe_n, 1'b0)
        `CHK(fpin, 1'b0)
        sense[0].sense_ocp = 1'b0;
        wt(4, 1'b1, RET + 14);
        cyc(20);
        $display("overcurrent done");
    endtask

    task automatic t_temp();
        temp = 1'b1;
        wt(4, 1'b0, 10);
        cyc(8);
        `CHK({hs_a, ls_a, hs_b, ls_b}, 8'h00)
        temp = 1'b0;
        wt(4, 1'b1, 10);
        cyc(20);
        `CHK(mon[3:0], 4'h9)
        $display("thermal done");
    endtask

    task automatic t_lock();
        lock = 1'b1;
        wt(4, 1'b0, 10);
        wt(5, 1'b0, 10);
        cyc(6);
        `CHK({hs_a, ls_a, hs_b, ls_b}, 8'h00)
        lock = 1'b0;
        wt(4, 1'b1, 10);
        `CHK(act, 1'b0)
        wt(5, 1'b1, WAK + 20);
        `CHK(n >= WAK - 4, 1'b1)
        $display("lockout done");
    endtask

    task automatic t_sleep();
        cyc(20);
        cmd[4] = 1'b0;
        wt(5, 1'b0, SLP + 12);
        `CHK(n >= SLP, 1'b1)
        cyc(6);
        `CHK({hs_a, ls_a, hs_b, ls_b}, 8'h00)
        $display("sleep done");
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_wake();
        t_decode();
        t_chop();
        t_ocp();
        t_temp();
        t_lock();
        t_sleep();
        print_verdict();
    end

    // About four times the expected run length
    initial begin
        #40us;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
